// *** rtl/adcc_pkg.sv ***
// shared constants, field layout and types for the conversion control block
package adcc_pkg;
    // register byte offsets
    localparam logic [3:0] ADCC_OFS_CFG = 4'h0;
    localparam logic [3:0] ADCC_OFS_RESULT = 4'h4;
    localparam logic [3:0] ADCC_OFS_STATUS = 4'h8;
    // configuration field positions
    localparam int ADCC_CFG_OS_BIT = 15;
    localparam int ADCC_CFG_INPUT_LSB = 12;
    localparam int ADCC_CFG_RANGE_LSB = 9;
    localparam int ADCC_CFG_MODE_BIT = 8;
    localparam int ADCC_CFG_RATE_LSB = 5;
    // reset values
    localparam logic [2:0] ADCC_RST_INPUT = 3'h0;
    localparam logic [2:0] ADCC_RST_RANGE = 3'h2;
    localparam logic ADCC_RST_MODE = 1'b1;
    localparam logic [2:0] ADCC_RST_RATE = 3'h4;
    // range code that gives the 2.048 V span
    localparam logic [2:0] ADCC_RANGE_2V048 = 3'h2;
    // timing: ref clock, oscillator, modulator and power-up
    localparam int ADCC_REF_HZ = 100_000_000;
    localparam int ADCC_OSC_HZ = 1_000_000;
    localparam int ADCC_OSC_DIV = ADCC_REF_HZ / ADCC_OSC_HZ;
    localparam int ADCC_MOD_DIV = 4;
    localparam int ADCC_PWRUP_US = 25;
    localparam logic [7:0] ADCC_PWRUP_TICKS =
        8'(ADCC_PWRUP_US * (ADCC_OSC_HZ / 1_000_000));

    typedef struct packed {
        logic [2:0] input_select_field;
        logic [2:0] range_select_field;
        logic single_mode;
        logic [2:0] rate_select_field;
    } adcc_cfg_t;

    typedef struct packed {
        logic [1:0] positive_converter_input;
        logic [1:0] negative_converter_input;
        logic negative_to_ground;
    } adcc_route_t;

    typedef enum logic [1:0] {ADCC_DOWN, ADCC_WAKE, ADCC_CONV} adcc_state_t;

    // samples per second for each rate code; code 7 repeats the fastest
    function automatic int adcc_rate_sps(input logic [2:0] code);
        case (code)
            3'h0: adcc_rate_sps = 128;
            3'h1: adcc_rate_sps = 250;
            3'h2: adcc_rate_sps = 490;
            3'h3: adcc_rate_sps = 920;
            3'h4: adcc_rate_sps = 1600;
            3'h5: adcc_rate_sps = 2400;
            default: adcc_rate_sps = 3300;
        endcase
    endfunction
endpackage

// *** rtl/adcc_conversion_control.sv ***
// conversion sequencing, configuration and result registers
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module adcc_conversion_control
    import adcc_pkg::*;
#(
    parameter int OSC_DIV = adcc_pkg::ADCC_OSC_DIV,
    parameter bit HAS_MUX = 1'b1,
    parameter bit HAS_GAIN = 1'b1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // converter core
    input wire logic [11:0] core_code,
    output logic core_power,
    output logic mod_clk,
    output adcc_pkg::adcc_route_t route,
    output logic [2:0] range_code,
    output logic [11:0] step_uv
);
    import adcc_pkg::*;
    // the only clock is ref_clk; the oscillator is derived below
    localparam int OSC_W = $clog2(OSC_DIV + 1);

    adcc_state_t state_r, state_nxt;
    adcc_cfg_t cfg_r, cfg_nxt, act_r, act_nxt;
    logic [OSC_W-1:0] osc_cnt_r;
    logic osc_tick_r;
    logic [1:0] mod_cnt_r;
    logic mod_clk_r;
    logic [12:0] conv_cnt_r, conv_cnt_nxt;
    logic [7:0] wake_cnt_r, wake_cnt_nxt;
    logic os_r, os_nxt;
    logic [11:0] result_r;
    logic core_power_r;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    adcc_route_t route_r;
    logic [2:0] range_r;
    logic [11:0] step_r;
    function automatic logic [12:0] conv_ticks(input logic [2:0] code);
        conv_ticks = 13'(ADCC_OSC_HZ / adcc_rate_sps(code));
    endfunction
    // input routing decode
    function automatic adcc_route_t route_of(input logic [2:0] sel);
        case (sel)
            3'h0: route_of = '{2'h0, 2'h1, 1'b0};
            3'h1: route_of = '{2'h0, 2'h3, 1'b0};
            3'h2: route_of = '{2'h1, 2'h3, 1'b0};
            3'h3: route_of = '{2'h2, 2'h3, 1'b0};
            default: route_of = '{sel[1:0], 2'h0, 1'b1};
        endcase
    endfunction
    function automatic logic [11:0] step_of(input logic [2:0] rng);
        case (rng)
            3'h0: step_of = 12'hBB8;
            3'h1: step_of = 12'h7D0;
            3'h2: step_of = 12'h3E8;
            3'h3: step_of = 12'h1F4;
            3'h4: step_of = 12'h0FA;
            default: step_of = 12'h07D;
        endcase
    endfunction
    // bus decode
    wire bus_req = read | write;
    wire bus_done = bus_req & ~waitrequest_r;
    wire wr_cfg = bus_done & write & (address == ADCC_OFS_CFG);
    wire start_req = wr_cfg & writedata[ADCC_CFG_OS_BIT];
    wire [12:0] conv_len = conv_ticks(act_r.rate_select_field);
    wire conv_done = (state_r == ADCC_CONV) & osc_tick_r
        & (conv_cnt_r == conv_len - 13'h1);
    wire wake_done = (state_r == ADCC_WAKE) & osc_tick_r
        & (wake_cnt_r == ADCC_PWRUP_TICKS - 8'h1);
    wire [2:0] eff_range = HAS_GAIN ? act_r.range_select_field
        : ADCC_RANGE_2V048;
    wire [2:0] eff_input = HAS_MUX ? act_r.input_select_field : 3'h0;
    wire [31:0] cfg_word = {16'h0, os_r, cfg_r.input_select_field,
        cfg_r.range_select_field, cfg_r.single_mode,
        cfg_r.rate_select_field, 5'h0};
    wire [31:0] rd_mux =
        (address == ADCC_OFS_CFG) ? cfg_word :
        (address == ADCC_OFS_RESULT) ? {20'h0, result_r} :
        (address == ADCC_OFS_STATUS) ? {30'h0, state_r} : 32'h0;

    // configuration register
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_cfg)
        begin
            cfg_nxt.input_select_field =
                writedata[ADCC_CFG_INPUT_LSB +: 3];
            cfg_nxt.range_select_field = writedata[ADCC_CFG_RANGE_LSB +: 3];
            cfg_nxt.single_mode = writedata[ADCC_CFG_MODE_BIT];
            cfg_nxt.rate_select_field =
                writedata[ADCC_CFG_RATE_LSB +: 3];
        end
    end

    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        act_nxt = act_r;
        conv_cnt_nxt = conv_cnt_r;
        wake_cnt_nxt = wake_cnt_r;
        os_nxt = os_r;
        unique case (state_r)
            ADCC_DOWN:
            begin
                wake_cnt_nxt = '0;
                // continuous mode wakes on its own, single-shot on request
                if (!cfg_r.single_mode || start_req)
                begin
                    state_nxt = ADCC_WAKE;
                    os_nxt = 1'b0;
                end
            end
            ADCC_WAKE:
            begin
                if (osc_tick_r)
                    wake_cnt_nxt = wake_cnt_r + 8'h1;
                if (wake_done)
                begin
                    state_nxt = ADCC_CONV;
                    act_nxt = cfg_nxt;
                    conv_cnt_nxt = '0;
                end
            end
            ADCC_CONV:
            begin
                // start writes land here and are dropped
                if (osc_tick_r)
                    conv_cnt_nxt = conv_cnt_r + 13'h1;
                if (conv_done)
                begin
                    conv_cnt_nxt = '0;
                    act_nxt = cfg_nxt;
                    if (act_r.single_mode || cfg_r.single_mode)
                    begin
                        state_nxt = ADCC_DOWN;
                        os_nxt = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_r <= ADCC_DOWN;
            cfg_r <= '{ADCC_RST_INPUT, ADCC_RST_RANGE, ADCC_RST_MODE,
                ADCC_RST_RATE};
            act_r <= '{ADCC_RST_INPUT, ADCC_RST_RANGE, ADCC_RST_MODE,
                ADCC_RST_RATE};
            conv_cnt_r <= '0;
            wake_cnt_r <= '0;
            os_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            act_r <= act_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            os_r <= os_nxt;
        end
    end

    // oscillator and modulator clock
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            osc_cnt_r <= '0;
            osc_tick_r <= 1'b0;
        end
        else
        begin
            osc_tick_r <= (osc_cnt_r == OSC_W'(OSC_DIV - 1));
            osc_cnt_r <= (osc_cnt_r == OSC_W'(OSC_DIV - 1)) ? '0
                : osc_cnt_r + OSC_W'(1);
        end
    end

    // modulator runs only while powered
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || state_r == ADCC_DOWN)
        begin
            mod_cnt_r <= '0;
            mod_clk_r <= 1'b0;
        end
        else if (osc_tick_r)
        begin
            mod_cnt_r <= mod_cnt_r + 2'h1;
            mod_clk_r <= (mod_cnt_r + 2'h1) < 2'(ADCC_MOD_DIV / 2);
        end
    end

    // result and derived outputs
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            result_r <= '0;
            route_r <= '0;
            range_r <= ADCC_RANGE_2V048;
            step_r <= '0;
            core_power_r <= 1'b0;
        end
        else
        begin
            route_r <= route_of(eff_input);
            range_r <= eff_range;
            step_r <= step_of(eff_range);
            core_power_r <= state_nxt != ADCC_DOWN;
            if (conv_done)
                result_r <= core_code;
        end
    end

    // bus slave: one wait state, read answer held until the next read
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            waitrequest_r <= 1'b1;
            readdata_r <= '0;
        end
        else
        begin
            waitrequest_r <= ~(bus_req & waitrequest_r);
            if (read & waitrequest_r)
                readdata_r <= rd_mux;
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign core_power = core_power_r;
    assign mod_clk = mod_clk_r;
    assign route = route_r;
    assign range_code = range_r;
    assign step_uv = step_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    property p_single_down;
        conv_done && act_r.single_mode |=> state_r == ADCC_DOWN && os_r;
    endproperty
    a_single_down: assert property (p_single_down)
        else $error("single-shot did not power down");
    property p_back_to_back;
        conv_done && !act_r.single_mode && !cfg_r.single_mode
            |=> state_r == ADCC_CONV && conv_cnt_r == 13'h0;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("gap between continuous conversions");
    property p_result_hold;
        !conv_done |=> $stable(result_r);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed outside completion");
    property p_ground;
        route_r.negative_to_ground |-> route_r.negative_converter_input
            == 2'h0;
    endproperty
    a_ground: assert property (p_ground)
        else $error("ground switch with routed negative input");
    // the power-down clear is judged by the state it saw, not the new one
    property p_mod_step;
        $changed(mod_clk_r) |-> $past(osc_tick_r || state_r == ADCC_DOWN);
    endproperty
    a_mod_step: assert property (p_mod_step)
        else $error("modulator clock moved off an oscillator tick");
    property p_fixed_range;
        !HAS_GAIN |-> range_r == ADCC_RANGE_2V048;
    endproperty
    a_fixed_range: assert property (p_fixed_range)
        else $error("fixed variant range not 2.048 V");
    property p_count_bound;
        state_r == ADCC_CONV |-> conv_cnt_r < conv_len;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("conversion ran past its period");
    property p_start;
        state_r == ADCC_DOWN && start_req |=> state_r == ADCC_WAKE && !os_r;
    endproperty
    a_start: assert property (p_start)
        else $error("start request not taken");
    property p_ignore;
        state_r == ADCC_CONV && start_req && !conv_done
            |=> state_r == ADCC_CONV && $stable(act_r);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("start during conversion had effect");
    property p_cfg_hold;
        state_r == ADCC_CONV && !conv_done |=> $stable(act_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed mid-conversion");
    property p_wake;
        wake_done |=> state_r == ADCC_CONV;
    endproperty
    a_wake: assert property (p_wake)
        else $error("power-up did not start conversion");
endmodule // adcc_conversion_control

// *** bench/adcc_core_model.sv ***
// converter core stand-in: code counts cycles since power-up
`timescale 1ns/1ns
module adcc_core_model
(
    // clock
    input wire logic ref_clk,
    // core side
    input wire logic core_power,
    output logic [11:0] core_code
);
    logic [11:0] cnt_r = 12'h000;
    logic tgl_r = 1'b0;
    // an unpowered core shows a pattern that moves every cycle
    assign core_code = core_power ? cnt_r : {6{tgl_r, ~tgl_r}};
    always_ff @(posedge ref_clk)
    begin
        tgl_r <= ~tgl_r;
        cnt_r <= core_power ? cnt_r + 12'h001 : 12'h000;
    end
endmodule // adcc_core_model

// *** bench/tb.sv ***
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module tb;
    import adcc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [11:0] core_code;
    logic core_power;
    logic mod_clk;
    adcc_route_t route;
    logic [2:0] range_code;
    logic [11:0] step_uv;
    adcc_route_t route_f;
    logic [2:0] range_f;
    logic [11:0] step_f;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] q;
    logic [11:0] r0, r1;
    logic [4:0] rt [4] = '{5'h02, 5'h06, 5'h0E, 5'h16};
    logic [11:0] stp [8] = '{12'hBB8, 12'h7D0, 12'h3E8, 12'h1F4,
        12'h0FA, 12'h07D, 12'h07D, 12'h07D};
    always #5 ref_clk = ~ref_clk;
    // OSC_DIV of 2 keeps every conversion short
    adcc_conversion_control #(.OSC_DIV(2)) dut_u (.ref_clk(ref_clk),
        .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .core_code(core_code),
        .core_power(core_power), .mod_clk(mod_clk), .route(route),
        .range_code(range_code), .step_uv(step_uv));
    adcc_core_model core_u (.ref_clk(ref_clk), .core_power(core_power),
        .core_code(core_code));
    // fixed-span single-channel variant rides on the same bus writes
    adcc_conversion_control #(.OSC_DIV(2), .HAS_MUX(1'b0),
        .HAS_GAIN(1'b0)) dut_fix_u (.ref_clk(ref_clk), .nrst(nrst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(), .waitrequest(),
        .core_code(core_code), .core_power(), .mod_clk(),
        .route(route_f), .range_code(range_f), .step_uv(step_f));
    task complete_run;
    begin
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // request stands until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
    begin
        k = 0;
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= d;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0 && k < 50)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk(32'(k < 50), 32'h1);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // one idle edge keeps strobes from being driven twice in a step
        @(posedge ref_clk);
    end
    endtask
    task wait_idle;
        int k;
    begin
        k = 0;
        q = 32'h0;
        while (q[15] !== 1'b1 && k < 1000)
        begin
            bus(1'b0, ADCC_OFS_CFG, 32'h0);
            k++;
        end
        chk(32'(q[15]), 32'h1);
    end
    endtask
    task nxt(output logic [11:0] r);
        int k;
        logic [11:0] p;
    begin
        bus(1'b0, ADCC_OFS_RESULT, 32'h0);
        p = q[11:0];
        k = 0;
        while (q[11:0] === p && k < 2000)
        begin
            bus(1'b0, ADCC_OFS_RESULT, 32'h0);
            k++;
        end
        r = q[11:0];
    end
    endtask
    task t_reset;
    begin
        bus(1'b0, ADCC_OFS_CFG, 32'h0);
        chk(q, 32'h8580);
        bus(1'b0, ADCC_OFS_STATUS, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, ADCC_OFS_RESULT, 32'h0);
        chk(q, 32'h0);
        chk(32'(step_uv), 32'h3E8);
        chk(32'(core_power), 32'h0);
    end
    endtask
    task t_fields;
        logic [31:0] v, w;
    begin
        for (int i = 0; i < 8; i++)
        begin
            v = 32'(i);
            w = (v << 12) | (v << 9) | 32'h100 | (v << 5);
            bus(1'b1, ADCC_OFS_CFG, w);
            bus(1'b0, ADCC_OFS_CFG, 32'h0);
            chk(q, w | 32'h8000);
            // outputs follow the settings in use, so run one fast conversion
            w = (w & 32'h7F1F) | 32'h80E0;
            bus(1'b1, ADCC_OFS_CFG, w);
            wait_idle();
            chk(32'(range_f), 32'h2);
            chk(32'(step_f), 32'h3E8);
            chk(32'(route_f), 32'h2);
            chk(32'(range_code), v);
            chk(32'(step_uv), 32'(stp[i]));
            if (i < 4)
                chk(32'(route), 32'(rt[i]));
            else
                chk(32'({route.positive_converter_input,
                    route.negative_to_ground}), (v & 32'h3) * 2 + 1);
        end
        bus(1'b1, 4'hC, 32'hFFFF);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, ADCC_OFS_CFG, 32'h0);
        chk(q, w | 32'h8000);
    end
    endtask
    task t_single;
        time t0;
    begin
        bus(1'b1, ADCC_OFS_CFG, 32'h85E0);
        bus(1'b0, ADCC_OFS_CFG, 32'h0);
        chk(32'(q[15]), 32'h0);
        bus(1'b0, ADCC_OFS_STATUS, 32'h0);
        chk(q, 32'h1);
        repeat (60) @(posedge ref_clk);
        bus(1'b0, ADCC_OFS_STATUS, 32'h0);
        chk(q, 32'h2);
        // a second start mid-conversion must not restart it
        bus(1'b1, ADCC_OFS_CFG, 32'h85E0);
        @(posedge mod_clk);
        t0 = $time;
        @(posedge mod_clk);
        chk(32'(($time - t0) / 10), 32'h8);
        @(posedge ref_clk);
        wait_idle();
        bus(1'b0, ADCC_OFS_RESULT, 32'h0);
        // 25 wake ticks plus 303 conversion ticks, two cycles each
        chk(32'(q[11:0] >= 12'h28C && q[11:0] <= 12'h294), 32'h1);
        chk(32'(core_power), 32'h0);
        bus(1'b0, ADCC_OFS_STATUS, 32'h0);
        chk(q, 32'h0);
    end
    endtask
    task t_cont;
        int k;
    begin
        bus(1'b1, ADCC_OFS_CFG, 32'h04E0);
        nxt(r0);
        nxt(r1);
        chk(32'(r1 - r0), 32'h25E);
        bus(1'b1, ADCC_OFS_CFG, 32'h04A0);
        nxt(r0);
        chk(32'(r0 - r1), 32'h25E);
        nxt(r1);
        chk(32'(r1 - r0), 32'h340);
        bus(1'b1, ADCC_OFS_CFG, 32'h05A0);
        k = 0;
        while (core_power !== 1'b0 && k < 1000)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk(32'(core_power), 32'h0);
        @(posedge ref_clk);
    end
    endtask
    initial
    begin
        #400_000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_fields();
        t_single();
        t_cont();
        complete_run();
    end
endmodule // tb
